// ---- hw/scg_crc_core.sv ----
// serial crc generator/checker with avalon-mm registers and interrupt
`timescale 1ns/100ps
module scg_crc_core
  import scg_pkg::*;
(
  input wire logic clock,
  input wire logic nrst,
  input wire logic clkEn,
  input wire logic shiftClockN,
  input wire logic serialData,
  input wire logic checkWordEnable,
  input wire logic masterClear,
  input wire logic presetN,
  input wire logic [2:0] polySelect,
  output logic serialOut,
  output logic errorFlag,
  output logic irq,
  input wire logic [3:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest
);

  ////////////////////////////////////////////////////////////////////////
  // polynomial decode

  // taps without the implied top term
  function automatic logic [SCG_W-1:0] tapsOf(input scg_sel_t sel);
    unique case (sel)
      SCG_CRC16: tapsOf = SCG_TAP_CRC16;
      SCG_CRC16R: tapsOf = SCG_TAP_CRC16R;
      SCG_ALT16: tapsOf = SCG_TAP_ALT16;
      SCG_CRC12: tapsOf = SCG_TAP_CRC12;
      SCG_POLY8: tapsOf = SCG_TAP_POLY8;
      SCG_LRC8: tapsOf = SCG_TAP_LRC8;
      SCG_CCITT: tapsOf = SCG_TAP_CCITT;
      SCG_CCITTR: tapsOf = SCG_TAP_CCITTR;
    endcase
  endfunction

  function automatic logic [4:0] degOf(input scg_sel_t sel);
    unique case (sel)
      SCG_CRC12: degOf = SCG_DEG12;
      SCG_POLY8, SCG_LRC8: degOf = SCG_DEG8;
      default: degOf = SCG_DEG16;
    endcase
  endfunction

  // keep only the low 'deg' bits of a word
  function automatic logic [SCG_W-1:0] lowMask(input logic [4:0] deg);
    lowMask = SCG_PRE_16 >> (5'h10 - deg);
  endfunction

  // bit deg-1 of a word: the active msb
  function automatic logic msbOf(input logic [SCG_W-1:0] v, input logic [4:0] deg);
    logic [3:0] idx;
    idx = 4'(deg - 5'h01);
    msbOf = v[idx];
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // pin synchronisation

  scg_pins_t pinsRaw;
  scg_pins_t pins;
  logic [SCG_PIN_W-1:0] pinsFlip;
  logic [SCG_PIN_W-1:0] pinsSync;
  logic clkLevel_reg;

  assign pinsRaw = '{shiftClockN, serialData, checkWordEnable, masterClear,
                     presetN, polySelect};
  // flipped so the synchroniser's zero reset reads as idle pins; otherwise
  // a preset and a shift clock fall would be seen right after reset
  assign pinsFlip = pinsRaw ^ SCG_PIN_IDLE;
  assign pins = pinsSync ^ SCG_PIN_IDLE;

  scg_pin_sync scg_pin_sync_inst (
    .clock(clock),
    .nrst(nrst),
    .clkEn(clkEn),
    .pinIn(pinsFlip),
    .pinOut(pinsSync)
  );

  // previous filtered shift clock, for edge detection
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      clkLevel_reg <= 1'b1; // idle level, no false fall after reset
    end else if (clkEn) begin
      clkLevel_reg <= pins.shiftClockN;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // register bus decode

  logic [SCG_W-1:0] crc_reg;
  logic [SCG_W-1:0] crc_next;
  logic serialOut_reg;
  logic errorFlag_reg;
  logic irq_reg;
  logic [SCG_IRQ_W-1:0] irqStat_reg;
  logic [SCG_IRQ_W-1:0] irqStat_next;
  logic [SCG_IRQ_W-1:0] irqMask_reg;
  logic [31:0] rdData_reg;
  logic [31:0] rdData_next;
  logic wait_reg;

  wire busReq = avs_read | avs_write;
  // a request completes at the edge where waitrequest is seen low
  wire busDone = busReq & ~wait_reg;
  wire wrDone = avs_write & ~wait_reg;
  wire lane0 = avs_byteenable[0];
  wire hitCtrl = avs_address == SCG_OFF_CTRL;
  wire hitStat = avs_address == SCG_OFF_STAT;
  wire hitIrq = avs_address == SCG_OFF_IRQ;
  wire hitMask = avs_address == SCG_OFF_MASK;
  wire swClear = wrDone & hitCtrl & lane0 & avs_writedata[SCG_CTRL_CLR];
  wire swPreset = wrDone & hitCtrl & lane0 & avs_writedata[SCG_CTRL_PRE];
  wire [SCG_IRQ_W-1:0] w1c = (wrDone & hitIrq & lane0) ?
                             avs_writedata[SCG_IRQ_W-1:0] : '0;

  // read mux; unmapped addresses and the control word read as zero
  wire [31:0] statWord = {11'h000, pins.checkWordEnable, pins.polySelect,
                          errorFlag_reg, crc_reg};
  always_comb begin
    rdData_next = SCG_RD_ZERO;
    if (hitStat) begin
      rdData_next = statWord;
    end else if (hitIrq) begin
      rdData_next[SCG_IRQ_W-1:0] = irqStat_reg;
    end else if (hitMask) begin
      rdData_next[SCG_IRQ_W-1:0] = irqMask_reg;
    end
  end

  // one wait state: data is latched while waitrequest is high
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      wait_reg <= 1'b1;
      rdData_reg <= SCG_RD_ZERO;
    end else if (clkEn) begin
      wait_reg <= ~(busReq & wait_reg);
      if (avs_read & wait_reg) begin
        rdData_reg <= rdData_next;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // crc datapath
  // limitation: the pin path costs 4-5 clocks, so shift clock phases and
  // data setup must each last at least five system clocks

  scg_sel_t sel;
  logic [SCG_W-1:0] taps;
  logic [SCG_W-1:0] keep;
  logic [4:0] deg;
  logic msb;
  logic fb;
  logic shiftEdge;
  logic doClear;
  logic doPreset;
  logic [SCG_W-1:0] presetVal;
  logic [SCG_W-1:0] shifted;

  assign sel = scg_sel_t'(pins.polySelect);
  assign taps = tapsOf(sel);
  assign deg = degOf(sel);
  assign keep = lowMask(deg);
  assign msb = msbOf(crc_reg, deg);
  // feedback is gated off while the check word shifts out
  assign fb = pins.checkWordEnable & (pins.serialData ^ msb);
  // falling edge of the filtered shift clock
  assign shiftEdge = clkLevel_reg & ~pins.shiftClockN;
  assign doClear = pins.masterClear | swClear;
  assign doPreset = ~pins.presetN | swPreset;
  assign presetVal = (deg == SCG_DEG16) ? SCG_PRE_16 :
                     (deg == SCG_DEG12) ? SCG_PRE_12 : SCG_PRE_8;
  // modulo-two division step within the active length
  assign shifted = ((crc_reg << 1) & keep) ^ (fb ? taps : '0);

  // clear beats preset beats shifting
  always_comb begin
    crc_next = crc_reg;
    if (doClear) begin
      crc_next = SCG_RST_CRC;
    end else if (doPreset) begin
      crc_next = presetVal;
    end else if (shiftEdge) begin
      crc_next = shifted;
    end
  end

  // flags track the next register value; errorFlag matches it every cycle, serialOut only while the select code holds steady
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      crc_reg <= SCG_RST_CRC;
      serialOut_reg <= 1'b0;
      errorFlag_reg <= 1'b0;
    end else if (clkEn) begin
      crc_reg <= crc_next;
      serialOut_reg <= msbOf(crc_next, deg);
      errorFlag_reg <= |crc_next;
    end
  end

  assign serialOut = serialOut_reg;
  assign errorFlag = errorFlag_reg;

  ////////////////////////////////////////////////////////////////////////
  // interrupt status and mask

  wire errRise = ~errorFlag_reg & (|crc_next);
  wire [SCG_IRQ_W-1:0] irqEvt = {errRise, shiftEdge};

  // a new event wins over a write-one clear in the same cycle
  assign irqStat_next = (irqStat_reg & ~w1c) | irqEvt;

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      irqStat_reg <= '0;
      irqMask_reg <= SCG_RST_MASK;
      irq_reg <= 1'b0;
    end else if (clkEn) begin
      irqStat_reg <= irqStat_next;
      if (wrDone & hitMask & lane0) begin
        irqMask_reg <= avs_writedata[SCG_IRQ_W-1:0];
      end
      irq_reg <= |(irqStat_next & irqMask_reg);
    end
  end

  assign irq = irq_reg;
  assign avs_readdata = rdData_reg;
  assign avs_waitrequest = wait_reg;

  ////////////////////////////////////////////////////////////////////////
  // checks

  default clocking cb @(posedge clock); endclocking
  default disable iff (!nrst || !clkEn);
  // remainder and flags share one edge, so checks compare same-cycle values

  clear_empties_a: assert property (
    doClear |=> crc_reg == SCG_RST_CRC)
    else $error("clear did not empty the register");

  preset_image_a: assert property (
    (doPreset && !doClear) |=> crc_reg == $past(presetVal))
    else $error("preset image wrong");

  preset_len_a: assert property (
    (doPreset && !doClear && deg == SCG_DEG12) |=> crc_reg == 16'hFFF0)
    else $error("12-bit preset image wrong");

  hold_no_edge_a: assert property (
    (!shiftEdge && !doClear && !doPreset) |=> $stable(crc_reg))
    else $error("register moved without a falling shift clock");

  shift_nofb_a: assert property (
    (shiftEdge && !doClear && !doPreset && !pins.checkWordEnable)
    |=> crc_reg == (($past(crc_reg) << 1) & $past(keep)))
    else $error("feedback not suppressed");

  upper_zero_a: assert property (
    (deg == SCG_DEG8 && shiftEdge && !doClear && !doPreset)
    |=> crc_reg[15:8] == 8'h00)
    else $error("short remainder left the low bits");

  upper12_zero_a: assert property (
    (deg == SCG_DEG12 && shiftEdge && !doClear && !doPreset)
    |=> crc_reg[15:12] == 4'h0)
    else $error("12-bit remainder left the low bits");

  error_flag_a: assert property (
    errorFlag == (crc_reg != SCG_RST_CRC))
    else $error("error flag disagrees with register");

  serial_msb_a: assert property (
    $stable(deg) |-> serialOut == msbOf(crc_reg, deg))
    else $error("serial output is not the active msb");

  // the interrupt flop sees a mask write one cycle late
  irq_level_a: assert property (
    irq == |(irqStat_reg & $past(irqMask_reg)))
    else $error("interrupt level wrong");

  bus_wait_a: assert property (
    (busReq && wait_reg) |=> !wait_reg ##1 wait_reg)
    else $error("waitrequest not one cycle");

  bus_done_a: assert property (
    busDone |=> wait_reg)
    else $error("waitrequest did not return high");

  wait_idle_a: assert property (
    !busReq |=> wait_reg)
    else $error("waitrequest low without a request");

  shift_fb_a: assert property (
    (shiftEdge && !doClear && !doPreset && pins.checkWordEnable)
    |=> crc_reg == ((($past(crc_reg) << 1) & $past(keep)) ^
    (($past(pins.serialData) ^ $past(msb)) ? $past(taps) : 16'h0000)))
    else $error("feedback step wrong");

  irq_set_a: assert property (
    (|irqEvt) |=> (irqStat_reg & $past(irqEvt)) == $past(irqEvt))
    else $error("interrupt event lost");

  w1c_clear_a: assert property (
    (|(w1c & ~irqEvt)) |=> (irqStat_reg & $past(w1c & ~irqEvt)) == '0)
    else $error("write-one clear ignored");

  mask_write_a: assert property (
    (wrDone && hitMask && lane0) |=> irqMask_reg == $past(avs_writedata[SCG_IRQ_W-1:0]))
    else $error("mask write lost");

  shift_cover_c: cover property (shiftEdge && pins.checkWordEnable);
  cw_cover_c: cover property (shiftEdge && !pins.checkWordEnable);
  zero_cover_c: cover property (shiftEdge ##1 !errorFlag);
  preset_cover_c: cover property (doPreset && deg == SCG_DEG8);
  irq_cover_c: cover property (errRise ##1 irq);
endmodule

// ---- hw/scg_pkg.sv ----
// shared constants and types for the serial crc generator/checker
package scg_pkg;
  localparam int SCG_W = 16;
  // register byte offsets
  localparam logic [3:0] SCG_OFF_CTRL = 4'h0;
  localparam logic [3:0] SCG_OFF_STAT = 4'h4;
  localparam logic [3:0] SCG_OFF_IRQ = 4'h8;
  localparam logic [3:0] SCG_OFF_MASK = 4'hC;
  // control fields (write-one pulses)
  localparam int SCG_CTRL_CLR = 0;
  localparam int SCG_CTRL_PRE = 1;
  // status fields
  localparam int SCG_STAT_ERR = 16;
  localparam int SCG_STAT_SEL = 17;
  localparam int SCG_STAT_CWE = 20;
  // interrupt fields
  localparam int SCG_IRQ_W = 2;
  localparam int SCG_IRQ_SHIFT = 0;
  localparam int SCG_IRQ_ERR = 1;
  // reset values
  localparam logic [SCG_W-1:0] SCG_RST_CRC = 16'h0000;
  localparam logic [SCG_IRQ_W-1:0] SCG_RST_MASK = 2'h0;
  localparam logic [31:0] SCG_RD_ZERO = 32'h0000_0000;
  // preset images for the three register lengths
  localparam logic [SCG_W-1:0] SCG_PRE_16 = 16'hFFFF;
  localparam logic [SCG_W-1:0] SCG_PRE_12 = 16'hFFF0;
  localparam logic [SCG_W-1:0] SCG_PRE_8 = 16'hFF00;
  // pin synchroniser depth
  localparam int SCG_SYNC_N = 3;
  localparam int SCG_PIN_W = 8;
  // polynomial selections, in select-code order
  typedef enum logic [2:0] {
    SCG_CRC16 = 3'h0,
    SCG_CRC16R = 3'h1,
    SCG_ALT16 = 3'h2,
    SCG_CRC12 = 3'h3,
    SCG_POLY8 = 3'h4,
    SCG_LRC8 = 3'h5,
    SCG_CCITT = 3'h6,
    SCG_CCITTR = 3'h7
  } scg_sel_t;
  // low-order taps, top term implied by the degree
  localparam logic [SCG_W-1:0] SCG_TAP_CRC16 = 16'h8005;
  localparam logic [SCG_W-1:0] SCG_TAP_CRC16R = 16'h4003;
  localparam logic [SCG_W-1:0] SCG_TAP_ALT16 = 16'hA097;
  localparam logic [SCG_W-1:0] SCG_TAP_CRC12 = 16'h080F;
  localparam logic [SCG_W-1:0] SCG_TAP_POLY8 = 16'h00B3;
  localparam logic [SCG_W-1:0] SCG_TAP_LRC8 = 16'h0001;
  localparam logic [SCG_W-1:0] SCG_TAP_CCITT = 16'h1021;
  localparam logic [SCG_W-1:0] SCG_TAP_CCITTR = 16'h0811;
  localparam logic [4:0] SCG_DEG16 = 5'h10;
  localparam logic [4:0] SCG_DEG12 = 5'h0C;
  localparam logic [4:0] SCG_DEG8 = 5'h08;
  // pins from the serial data logic
  typedef struct packed {
    logic shiftClockN;
    logic serialData;
    logic checkWordEnable;
    logic masterClear;
    logic presetN;
    logic [2:0] polySelect;
  } scg_pins_t;
  // idle pin levels: shift clock high, preset released, all else low
  localparam scg_pins_t SCG_PIN_IDLE = '{1'h1, 1'h0, 1'h0, 1'h0, 1'h1, 3'h0};
endpackage

// ---- hw/scg_pin_sync.sv ----
// three-stage pin synchroniser with agreement filter
`timescale 1ns/100ps
module scg_pin_sync
  import scg_pkg::*;
(
  input wire logic clock,
  input wire logic nrst,
  input wire logic clkEn,
  input wire logic [SCG_PIN_W-1:0] pinIn,
  output logic [SCG_PIN_W-1:0] pinOut
);
  logic [SCG_PIN_W-1:0] stage1_reg;
  logic [SCG_PIN_W-1:0] stage2_reg;
  logic [SCG_PIN_W-1:0] stage3_reg;
  logic [SCG_PIN_W-1:0] held_reg;
  logic [SCG_PIN_W-1:0] agree;
  logic [SCG_PIN_W-1:0] held_next;

  // a bit changes only once stages two and three agree
  assign agree = ~(stage2_reg ^ stage3_reg);
  assign held_next = (agree & stage3_reg) | (~agree & held_reg);
  assign pinOut = held_reg;

  // stage1 feeds stage2 only; no logic looks at it
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      stage1_reg <= '0;
      stage2_reg <= '0;
      stage3_reg <= '0;
      held_reg <= '0;
    end else if (clkEn) begin
      stage1_reg <= pinIn;
      stage2_reg <= stage1_reg;
      stage3_reg <= stage2_reg;
      held_reg <= held_next;
    end
  end
endmodule

// ---- testbench/scg_link_model.sv ----
// far-side serial data logic that drives the crc pins
`timescale 1ns/100ps
module scg_link_model
  import scg_pkg::*;
(
  input wire logic clock,
  input wire logic serialOut,
  output scg_pins_t pins
);
  int gap = 6;
  logic lastOut;
  ////////////////////////////////////////////////////////////////////////////
  // idle pins: shift clock stands high between frames
  initial begin
    pins = '{1'b1, 1'b0, 1'b1, 1'b0, 1'b1, 3'h0};
    lastOut = 1'b0;
  end
  task automatic waitN(input int n);
    repeat (n) @(posedge clock);
  endtask
  // one bit frame; gap stretches it to model a slow sender
  task automatic shiftBit(input logic d, input logic check_word_enable);
    waitN(1);
    pins.serialData <= d;
    pins.checkWordEnable <= check_word_enable;
    waitN(gap);
    lastOut = check_word_enable ? d : serialOut;
    pins.shiftClockN <= 1'b0;
    waitN(gap + 2);
    pins.shiftClockN <= 1'b1;
    waitN(gap);
  endtask
  // clear or preset pulse, select set alongside so the image fits it
  task automatic clearPulse(input logic useClear, input logic [2:0] sel);
    waitN(1);
    pins.polySelect <= sel;
    if (useClear) pins.masterClear <= 1'b1;
    else pins.presetN <= 1'b0;
    waitN(gap + 2);
    pins.masterClear <= 1'b0;
    pins.presetN <= 1'b1;
    waitN(gap);
  endtask
endmodule

// ---- testbench/scg_crc_core_tb.sv ----
// self-checking bench for the serial crc generator/checker
`timescale 1ns/100ps
module scg_crc_core_tb
  import scg_pkg::*;
;
  localparam logic [15:0] TAPS [8] = '{SCG_TAP_CRC16, SCG_TAP_CRC16R, SCG_TAP_ALT16,
    SCG_TAP_CRC12, SCG_TAP_POLY8, SCG_TAP_LRC8, SCG_TAP_CCITT, SCG_TAP_CCITTR};
  logic clock = 1'b0;
  logic nrst = 1'b0;
  logic [3:0] avs_address = 4'h0;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0;
  logic [3:0] avs_byteenable = 4'hF;
  logic [31:0] avs_readdata;
  logic avs_waitrequest;
  logic serialOut, errorFlag, irq;
  scg_pins_t linkPins;
  int seed = 32'h701bdacf;
  int n_mismatch = 0;
  int num_checks = 0;
  int cyc = 0;
  ////////////////////////////////////////////////////////////////////////////
  scg_crc_core scg_crc_core_inst (.clock(clock), .nrst(nrst), .clkEn(1'b1),
    .shiftClockN(linkPins.shiftClockN), .serialData(linkPins.serialData),
    .checkWordEnable(linkPins.checkWordEnable), .masterClear(linkPins.masterClear),
    .presetN(linkPins.presetN), .polySelect(linkPins.polySelect),
    .serialOut(serialOut), .errorFlag(errorFlag), .irq(irq),
    .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest));
  scg_link_model scg_link_model_inst (.clock(clock), .serialOut(serialOut), .pins(linkPins));
  ////////////////////////////////////////////////////////////////////////////
  // clock and a hang limit well above the expected run length
  initial begin
    forever #2.5 clock = ~clock;
  end
  always @(posedge clock) begin
    cyc <= cyc + 1;
    if (cyc == 60000) begin
      n_mismatch++;
      wrap_up();
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  // expectation helpers: degree per select code and one shift step
  function automatic int degOf(input logic [2:0] s);
    return (s == 3'h3) ? 12 : (s == 3'h4 || s == 3'h5) ? 8 : 16;
  endfunction
  function automatic logic [15:0] stepCrc(input logic [15:0] r, input logic d,
      input logic check_word_enable, input logic [2:0] s);
    int g;
    logic fb;
    g = degOf(s);
    fb = check_word_enable & (d ^ r[g-1]);
    return ((r << 1) & (16'hFFFF >> (16 - g))) ^ (fb ? TAPS[s] : 16'h0000);
  endfunction
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // one avalon access, held until waitrequest is seen low
  task automatic avXfer(input logic wr, input logic [3:0] a, input logic [31:0] wd,
      output logic [31:0] rd);
    avs_address <= a;
    avs_writedata <= wd;
    avs_write <= wr;
    avs_read <= ~wr;
    do begin
      @(posedge clock);
    end while (avs_waitrequest !== 1'b0);
    rd = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
    @(posedge clock);
  endtask
  task automatic rdRem(output logic [31:0] d);
    avXfer(1'b0, SCG_OFF_STAT, 32'h0, d);
    d = {16'h0000, d[15:0]};
  endtask
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////////
  // main sequence
  initial begin
    logic [7:0] msg;
    logic [15:0] r, ck;
    logic [31:0] d;
    int g;
    repeat (5) @(posedge clock);
    nrst <= 1'b1;
    repeat (6) @(posedge clock);
    avXfer(1'b0, SCG_OFF_MASK, 32'h0, d);
    chk(d, {30'h0, SCG_RST_MASK});
    rdRem(d);
    chk(d, {16'h0, SCG_RST_CRC});
    chk(irq, 1'b0);
    $display("test reset done");
    // encode, transmit check word, then check good and corrupted copies
    for (int s = 0; s < 8; s++) begin
      g = degOf(s[2:0]);
      scg_link_model_inst.gap = 5 + ($random(seed) & 3);
      msg = (s == 0) ? 8'h00 : (s == 7) ? 8'hFF : 8'($random(seed));
      scg_link_model_inst.clearPulse(1'b1, s[2:0]);
      chk(errorFlag, 1'b0);
      r = 16'h0000;
      for (int i = 7; i >= 0; i--) begin
        scg_link_model_inst.shiftBit(msg[i], 1'b1);
        r = stepCrc(r, msg[i], 1'b1, s[2:0]);
      end
      chk(serialOut, r[g-1]);
      avXfer(1'b0, SCG_OFF_STAT, 32'h0, d);
      chk(d, {11'h000, 1'b1, s[2:0], r != 16'h0, r});
      chk(errorFlag, r != 16'h0);
      ck = r;
      for (int i = g - 1; i >= 0; i--) begin
        scg_link_model_inst.shiftBit(1'b0, 1'b0);
        chk(scg_link_model_inst.lastOut, ck[i]);
      end
      rdRem(d);
      chk(d, 32'h0);
      for (int e = 0; e < 2; e++) begin
        scg_link_model_inst.clearPulse(1'b1, s[2:0]);
        r = 16'h0000;
        for (int i = 7 + g; i >= 0; i--) begin
          logic b;
          b = (i > g - 1) ? msg[i-g] ^ (e == 1 && i == g + 3) : ck[i];
          scg_link_model_inst.shiftBit(b, 1'b1);
          r = stepCrc(r, b, 1'b1, s[2:0]);
        end
        chk(errorFlag, e[0]);
        rdRem(d);
        chk(d, {16'h0, r});
      end
      $display("test select %0d done", s);
    end
    // preset images for every select code
    for (int s = 0; s < 8; s++) begin
      scg_link_model_inst.clearPulse(1'b0, s[2:0]);
      rdRem(d);
      chk(d, {16'h0, ~(16'hFFFF >> degOf(s[2:0]))});
      chk(errorFlag, 1'b1);
    end
    $display("test preset done");
    // interrupt raise, mask, clear; soft clear and preset; unmapped place
    scg_link_model_inst.clearPulse(1'b1, 3'h4);
    avXfer(1'b1, SCG_OFF_IRQ, 32'h3, d);
    avXfer(1'b1, SCG_OFF_MASK, 32'h2, d);
    chk(irq, 1'b0);
    scg_link_model_inst.clearPulse(1'b0, 3'h4);
    chk(irq, 1'b1);
    avXfer(1'b0, SCG_OFF_IRQ, 32'h0, d);
    chk(d, 32'h2);
    avXfer(1'b1, SCG_OFF_MASK, 32'h0, d);
    repeat (2) @(posedge clock);
    chk(irq, 1'b0);
    avXfer(1'b1, SCG_OFF_IRQ, 32'h3, d);
    avXfer(1'b0, SCG_OFF_IRQ, 32'h0, d);
    chk(d, 32'h0);
    avXfer(1'b1, SCG_OFF_CTRL, 32'h1, d);
    rdRem(d);
    chk(d, 32'h0);
    avXfer(1'b1, SCG_OFF_CTRL, 32'h2, d);
    rdRem(d);
    chk(d, 32'hFF00);
    avXfer(1'b1, 4'h2, 32'h3, d);
    avXfer(1'b0, 4'h2, 32'h0, d);
    chk(d, SCG_RD_ZERO);
    avs_byteenable <= 4'h0;
    avXfer(1'b1, SCG_OFF_MASK, 32'h3, d);
    avs_byteenable <= 4'hF;
    avXfer(1'b0, SCG_OFF_MASK, 32'h0, d);
    chk(d, 32'h0);
    $display("test registers done");
    wrap_up();
  end
endmodule
